// file: include/asr_pkg.sv
// Constants for the converter status and identification register bank.
// Assumes a classic Wishbone master with 32-bit data and word-aligned registers.
package asr_pkg;
  localparam logic [5:0]  IDX_IDENT     = 6'h00;
  localparam logic [5:0]  IDX_STATUS    = 6'h01;
  localparam logic [5:0]  IDX_MODE      = 6'h02;
  localparam logic [5:0]  IDX_IRQ_STAT  = 6'h20;
  localparam logic [5:0]  IDX_IRQ_MASK  = 6'h21;
  localparam logic [5:0]  IDX_CHKSUM    = 6'h3E;
  localparam logic [5:0]  IDX_RSVD      = 6'h3F;
  localparam int          ST_LOCK       = 15;
  localparam int          ST_RESYNC     = 14;
  localparam int          ST_REGMAP     = 13;
  localparam int          ST_CRCERR     = 12;
  localparam int          MD_REGCRC_EN  = 13;
  localparam int          MD_RXCRC_EN   = 12;
  localparam int          MD_CRC_TYPE   = 11;
  localparam int          MD_RESET      = 10;
  localparam int          MD_WLEN_LO    = 8;
  localparam logic [15:0] STATUS_RST    = 16'h0500;
  localparam logic [15:0] MODE_RST      = 16'h0510;
  localparam logic [15:0] MODE_WMASK    = 16'h3F1F;
  localparam logic [15:0] CHKSUM_RST    = 16'h0000;
  localparam logic [15:0] POLY_CCITT    = 16'h1021;
  localparam logic [15:0] POLY_ANSI     = 16'h8005;
  localparam int          IRQ_NEW_LO    = 0;
  localparam int          IRQ_RESYNC    = 3;
  localparam int          IRQ_CRCERR    = 4;
  localparam int          IRQ_REGMAP    = 5;
  localparam int          IRQ_W         = 6;
  localparam logic [5:0]  IRQ_RST       = 6'h00;
endpackage : asr_pkg

// file: rtl/asr_regs.sv
// Status, identification, mode and checksum registers behind a Wishbone slave.
// Assumes link-side lines are levels or pulses timed by link_clk_i, outside clk_i.
module asr_regs #(
  parameter int         CHANNELS  = 3,
  parameter logic [3:0] IDENT_HI  = 4'h5,  // Arbitrary value.
  parameter logic [7:0] REVISION  = 8'hA5  // Arbitrary value.
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          link_clk_i,
  input  wire logic          lock_i,
  input  wire logic          resync_i,
  input  wire logic          crc_err_i,
  input  wire logic [2:0]    new_sample_i,
  input  wire logic [2:0]    result_read_i,
  output logic               irq_o
);
  localparam int SW = 10;

  logic [SW-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic          lclk_q, lclk_d, lock_q, lock_d;
  logic          ack_q, ack_d;
  logic [31:0]   dat_q, dat_d;
  logic [15:0]   mode_q, mode_d, chk_q, chk_d, chk_calc;
  logic          mode_wr_q, mode_wr_d;
  logic          rst_flag_q, rst_flag_d;
  logic          resync_q, resync_d, regmap_q, regmap_d, crcerr_q, crcerr_d;
  logic [2:0]    new_q, new_d;
  logic [asr_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ievt;
  logic          link_rise, resync_evt, crc_evt, regmap_evt;
  logic [2:0]    new_evt, rd_evt;
  logic          access, wr, rd;
  logic [5:0]    idx;
  logic [15:0]   status_w, ident_w;

  function automatic logic [15:0] crc16(input logic [15:0] data, input logic [15:0] poly);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ data[i]) ? ((c << 1) ^ poly) : (c << 1);
    end
    return c;
  endfunction : crc16

  // Link clock edges are found in the local domain, so events are counted once per link period.
  always_comb begin
    sync1_d    = {result_read_i, new_sample_i, crc_err_i, resync_i, lock_i, link_clk_i};
    sync2_d    = sync1_q;
    lclk_d     = sync2_q[0];
    lock_d     = sync2_q[1];
    link_rise  = sync2_q[0] & ~lclk_q;
    resync_evt = link_rise & sync2_q[2];
    crc_evt    = link_rise & sync2_q[3] & mode_q[asr_pkg::MD_RXCRC_EN];
    new_evt    = {3{link_rise}} & sync2_q[6:4];
    rd_evt     = {3{link_rise}} & sync2_q[9:7];
  end

  always_comb begin
    access   = wb_cyc_i & wb_stb_i & ~ack_q;
    wr       = access & wb_we_i;
    rd       = access & ~wb_we_i;
    idx      = wb_adr_i[7:2];
    ack_d    = access;
    ident_w  = {IDENT_HI, 4'(CHANNELS), REVISION};
    status_w = {lock_q, resync_q, regmap_q, crcerr_q,
                mode_q[asr_pkg::MD_CRC_TYPE], rst_flag_q,
                mode_q[asr_pkg::MD_WLEN_LO+1:asr_pkg::MD_WLEN_LO],
                5'h00, new_q};
    dat_d    = 32'h0000_0000;
    if (rd) begin
      unique case (idx)
        asr_pkg::IDX_IDENT:    dat_d = {16'h0000, ident_w};
        asr_pkg::IDX_STATUS:   dat_d = {16'h0000, status_w};
        asr_pkg::IDX_MODE:     dat_d = {16'h0000, mode_q[15:11], rst_flag_q, mode_q[9:0]};
        asr_pkg::IDX_IRQ_STAT: dat_d = {26'h0, ist_q};
        asr_pkg::IDX_IRQ_MASK: dat_d = {26'h0, imask_q};
        asr_pkg::IDX_CHKSUM:   dat_d = {16'h0000, chk_q};
        default:               dat_d = 32'h0000_0000;
      endcase
    end
  end

  // Only the mode word and the interrupt status and mask words take writes; identification and status have no write path.
  always_comb begin
    mode_d    = mode_q;
    mode_wr_d = 1'b0;
    if (wr && idx == asr_pkg::IDX_MODE) begin
      mode_wr_d = 1'b1;
      if (wb_sel_i[0]) mode_d[7:0] = wb_dat_i[7:0] & asr_pkg::MODE_WMASK[7:0];
      if (wb_sel_i[1]) mode_d[15:8] = wb_dat_i[15:8] & asr_pkg::MODE_WMASK[15:8];
    end
  end

  // A host write to the mode word changes the checksum on purpose, so it is not a fault.
  always_comb begin
    chk_calc   = crc16(mode_q, mode_q[asr_pkg::MD_CRC_TYPE] ? asr_pkg::POLY_ANSI : asr_pkg::POLY_CCITT);
    chk_d      = chk_calc;
    regmap_evt = mode_q[asr_pkg::MD_REGCRC_EN] & ~mode_wr_q & (chk_calc != chk_q);
  end

  // Flags that software clears by reading status lose to a new event in the same cycle.
  always_comb begin
    logic st_rd;
    st_rd      = rd && idx == asr_pkg::IDX_STATUS;
    resync_d   = resync_evt | (resync_q & ~st_rd);
    regmap_d   = regmap_evt | (regmap_q & ~st_rd);
    crcerr_d   = crc_evt | (crcerr_q & ~st_rd);
    new_d      = new_evt | (new_q & ~rd_evt);
    rst_flag_d = rst_flag_q;
    if (wr && idx == asr_pkg::IDX_MODE && wb_sel_i[1] && !wb_dat_i[asr_pkg::MD_RESET]) begin
      rst_flag_d = 1'b0;
    end
  end

  always_comb begin
    ievt = '0;
    ievt[asr_pkg::IRQ_NEW_LO+2:asr_pkg::IRQ_NEW_LO] = new_evt;
    ievt[asr_pkg::IRQ_RESYNC] = resync_evt;
    ievt[asr_pkg::IRQ_CRCERR] = crc_evt;
    ievt[asr_pkg::IRQ_REGMAP] = regmap_evt;
    ist_d   = ist_q;
    imask_d = imask_q;
    if (wr && wb_sel_i[0] && idx == asr_pkg::IDX_IRQ_STAT) ist_d = ist_q & ~wb_dat_i[asr_pkg::IRQ_W-1:0];
    if (wr && wb_sel_i[0] && idx == asr_pkg::IDX_IRQ_MASK) imask_d = wb_dat_i[asr_pkg::IRQ_W-1:0];
    ist_d = ist_d | ievt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      lclk_q     <= 1'b0;
      lock_q     <= 1'b0;
      ack_q      <= 1'b0;
      dat_q      <= 32'h0000_0000;
      mode_q     <= asr_pkg::MODE_RST;
      mode_wr_q  <= 1'b0;
      chk_q      <= asr_pkg::CHKSUM_RST;
      rst_flag_q <= asr_pkg::STATUS_RST[asr_pkg::MD_RESET];
      resync_q   <= 1'b0;
      regmap_q   <= 1'b0;
      crcerr_q   <= 1'b0;
      new_q      <= 3'h0;
      ist_q      <= asr_pkg::IRQ_RST;
      imask_q    <= asr_pkg::IRQ_RST;
    end else begin
      sync1_q    <= sync1_d;
      sync2_q    <= sync2_d;
      lclk_q     <= lclk_d;
      lock_q     <= lock_d;
      ack_q      <= ack_d;
      dat_q      <= dat_d;
      mode_q     <= mode_d;
      mode_wr_q  <= mode_wr_d;
      chk_q      <= chk_d;
      rst_flag_q <= rst_flag_d;
      resync_q   <= resync_d;
      regmap_q   <= regmap_d;
      crcerr_q   <= crcerr_d;
      new_q      <= new_d;
      ist_q      <= ist_d;
      imask_q    <= imask_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o    = |(ist_q & imask_q);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (access |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Wishbone ack not a single cycle after request.");
  a_lock_follows: assert property (sync2_q[1] |=> status_w[asr_pkg::ST_LOCK])
    else $error("Lock bit does not follow synchronised lock.");
  a_resync_sets: assert property (resync_evt |=> resync_q && ist_q[asr_pkg::IRQ_RESYNC])
    else $error("Resync event not latched.");
  a_regmap_gated: assert property ($rose(regmap_q) |-> $past(mode_q[asr_pkg::MD_REGCRC_EN]))
    else $error("Checksum fault raised while monitoring disabled.");
  a_crcerr_sets: assert property (crc_evt |=> status_w[asr_pkg::ST_CRCERR])
    else $error("Input checksum error not flagged.");
  a_reserved_zero: assert property (status_w[7:3] == 5'h00 && wb_dat_o[31:16] == 16'h0000)
    else $error("Reserved status bits not zero.");
  a_reset_clear: assert property (wr && idx == asr_pkg::IDX_MODE && wb_sel_i[1] && !wb_dat_i[10]
    |=> !status_w[10])
    else $error("Reset flag not cleared by mode write.");
  a_newdata_clear: assert property (rd_evt[0] && !new_evt[0] |=> !status_w[0])
    else $error("New-data flag not cleared after read-out.");
  a_status_read: assert property (rd && idx == asr_pkg::IDX_STATUS |=> wb_dat_o[15:0] == $past(status_w))
    else $error("Status read data mismatch.");
  a_ro_ignore: assert property (wr && idx == asr_pkg::IDX_STATUS |=> $stable(mode_q))
    else $error("Status write altered state.");

  // Sticky flags must be set by their event and cleared only by a status read that no event meets; the lock bit follows the lock line.
  a_regmap_sets: assert property (
    regmap_evt |=> status_w[asr_pkg::ST_REGMAP])
    else $error("Checksum fault not latched.");
  a_regmap_clear: assert property (
    rd && idx == asr_pkg::IDX_STATUS && !regmap_evt |=> !regmap_q)
    else $error("Checksum fault not cleared by status read.");
  a_regmap_hold: assert property (
    !mode_q[asr_pkg::MD_REGCRC_EN] |-> !regmap_evt)
    else $error("Checksum monitored while disabled.");
  a_resync_sticky: assert property (
    resync_q && !(rd && idx == asr_pkg::IDX_STATUS) |=> resync_q)
    else $error("Resync flag lost without a status read.");
  a_resync_clear: assert property (
    rd && idx == asr_pkg::IDX_STATUS && !resync_evt |=> !resync_q)
    else $error("Resync flag not cleared by status read.");
  a_crcerr_gated: assert property (
    !mode_q[asr_pkg::MD_RXCRC_EN] |-> !crc_evt)
    else $error("Input checksum error counted while disabled.");
  a_crcerr_clear: assert property (
    rd && idx == asr_pkg::IDX_STATUS && !crc_evt |=> !crcerr_q)
    else $error("Input checksum error not cleared by status read.");
  a_lock_drops: assert property (
    !sync2_q[1] |=> !status_w[asr_pkg::ST_LOCK])
    else $error("Lock bit stays set after unlock.");

  // Mode-derived status fields must mirror the mode word without delay.
  a_crctype_shown: assert property (
    status_w[11] == mode_q[asr_pkg::MD_CRC_TYPE])
    else $error("Polynomial select not shown in status.");
  a_wlen_shown: assert property (
    status_w[9:8] == mode_q[asr_pkg::MD_WLEN_LO+1:asr_pkg::MD_WLEN_LO])
    else $error("Word length not shown in status.");
  a_rstflag_holds: assert property (
    !rst_flag_q |=> !rst_flag_q)
    else $error("Reset flag set again without a reset.");
  a_mode_masked: assert property (
    (mode_q & ~asr_pkg::MODE_WMASK) == 16'h0000)
    else $error("Reserved mode bits became set.");

  // Each channel keeps its own new-data flag.
  a_new_sets0: assert property (
    new_evt[0] |=> status_w[0])
    else $error("Channel 0 new data not flagged.");
  a_new_sets1: assert property (
    new_evt[1] |=> status_w[1])
    else $error("Channel 1 new data not flagged.");
  a_new_sets2: assert property (
    new_evt[2] |=> status_w[2])
    else $error("Channel 2 new data not flagged.");
  a_new_clear1: assert property (
    rd_evt[1] && !new_evt[1] |=> !status_w[1])
    else $error("Channel 1 flag not cleared after read-out.");
  a_new_clear2: assert property (
    rd_evt[2] && !new_evt[2] |=> !status_w[2])
    else $error("Channel 2 flag not cleared after read-out.");

  // Interrupt status is sticky, and a new event beats a clear in the same cycle.
  a_set_wins: assert property (
    ievt[asr_pkg::IRQ_RESYNC] |=> ist_q[asr_pkg::IRQ_RESYNC])
    else $error("Interrupt event lost to a clear.");
  a_irq_sets: assert property (
    |(ievt & imask_q) && !(wr && idx == asr_pkg::IDX_IRQ_MASK) |=> irq_o)
    else $error("Unmasked event did not raise the interrupt.");
  a_irq_quiet: assert property (
    imask_q == '0 |-> !irq_o)
    else $error("Interrupt raised while fully masked.");
  a_mask_write: assert property (
    wr && wb_sel_i[0] && idx == asr_pkg::IDX_IRQ_MASK |=> imask_q == $past(wb_dat_i[asr_pkg::IRQ_W-1:0]))
    else $error("Mask write did not land.");

  // Bus side: read data is only driven alongside ack, and writes to fixed words change nothing.
  a_data_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("Read data driven outside ack.");
  a_ack_quiet: assert property (
    !access |=> !wb_ack_o)
    else $error("Ack without request.");
  a_ident_ro: assert property (
    wr && idx == asr_pkg::IDX_IDENT |=> $stable(mode_q) && $stable(imask_q))
    else $error("Identification write altered state.");
  a_ident_count: assert property (
    ident_w[11:8] == 4'(CHANNELS))
    else $error("Channel count field wrong.");

  c_status_read: cover property (rd && idx == asr_pkg::IDX_STATUS ##1 wb_ack_o);
  c_mode_write: cover property (wr && idx == asr_pkg::IDX_MODE);
  c_new_clear: cover property (rd_evt != 3'h0);
  c_resync: cover property (resync_evt ##[1:20] rd && idx == asr_pkg::IDX_STATUS);
  c_irq_rise: cover property ($rose(irq_o));
endmodule : asr_regs

// file: testbench/asr_link_model.sv
// Converter link side: makes the link clock only within frames.
// Assumes the bench calls its tasks one at a time, by hierarchical name.
module asr_link_model;
  timeunit 1ns;
  timeprecision 100ps;
  logic       link_clk = 1'b0;
  logic       lock     = 1'b0;
  logic       resync   = 1'b0;
  logic       crc_err  = 1'b0;
  logic [2:0] fresh    = 3'h0;
  logic [2:0] taken    = 3'h0;
  task automatic set_lock(input logic v);
    lock = v;
  endtask : set_lock
  // Events stand across one rising edge only, so each is counted once.
  task automatic frame(input logic r, input logic c, input logic [2:0] n, input logic [2:0] t);
    {resync, crc_err, fresh, taken} = {r, c, n, t};
    #31.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
    {resync, crc_err, fresh, taken} = 8'h00;
    #31.0;
  endtask : frame
endmodule : asr_link_model

// file: testbench/asr_regs_test.sv
// Self-checking bench for the status and identification register bank.
// Assumes the link model sits beside the design and a 100 MHz clock.
module asr_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] ID_HI = 4'h5;  // Arbitrary value.
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] dat   = 32'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  int          n_mismatch = 0;
  int          n_compared = 0;
  asr_link_model u_link();
  asr_regs #(.IDENT_HI(ID_HI)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .link_clk_i(u_link.link_clk), .lock_i(u_link.lock), .resync_i(u_link.resync),
    .crc_err_i(u_link.crc_err), .new_sample_i(u_link.fresh), .result_read_i(u_link.taken),
    .irq_o(irq));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until ack is sampled high; read data is taken at that edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, sel} <= {2'b11, 4'hF};
    {we, adr, dat} <= {w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    r = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd
  task automatic link(input logic r, input logic c, input logic [2:0] n, input logic [2:0] t);
    u_link.frame(r, c, n, t);
    repeat (10) @(posedge clk_i);
  endtask : link
  task automatic t_reset;
    logic [31:0] r;
    rd(8'h04, 32'h0500);
    wb(1'b0, 8'h00, 32'h0, r);
    chk(r & 32'hFF00, {16'h0, ID_HI, 4'h3, 8'h00});
    wr(8'h04, 32'hFFFF);
    wr(8'h00, 32'h0);
    rd(8'h04, 32'h0500);
    rd(8'h40, 32'h0);
    $display("test reset and read-only done");
  endtask : t_reset
  task automatic t_mode;
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {20'h0, 1'(i), 1'b0, 2'(i), 8'h00};
      wr(8'h08, v);
      rd(8'h04, v);
    end
    $display("test mode fields done");
  endtask : t_mode
  task automatic t_events;
    wr(8'h84, 32'h3F);
    link(1'b0, 1'b1, 3'h0, 3'h0);
    rd(8'h04, 32'h0B00);
    wr(8'h08, 32'h1000);
    u_link.set_lock(1'b1);
    link(1'b1, 1'b1, 3'h5, 3'h0);
    chk({31'h0, irq}, 32'h1);
    rd(8'h80, 32'h1D);
    rd(8'h04, 32'hD005);
    rd(8'h04, 32'h8005);
    link(1'b0, 1'b0, 3'h0, 3'h5);
    rd(8'h04, 32'h8000);
    wr(8'h80, 32'h3F);
    chk({31'h0, irq}, 32'h0);
    wr(8'h84, 32'h0);
    link(1'b0, 1'b0, 3'h2, 3'h0);
    chk({31'h0, irq}, 32'h0);
    rd(8'h80, 32'h02);
    rd(8'h04, 32'h8002);
    wr(8'h08, 32'h2000);
    rd(8'h04, 32'h8002);
    rd(8'hF8, 32'h06E6);
    $display("test events done");
  endtask : t_events
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_mode;
    t_events;
    test_done;
  end
  // The tests take some 2 us; a hang beyond 100 us is cut short.
  initial begin
    #100us;
    n_mismatch++;
    test_done;
  end
endmodule : asr_regs_test
